// file: src/ipc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defs.svh"
module ipc_host
  import ipc_pkg::*;
(
  input  wire logic                 CORE_CLK,
  input  wire logic                 SRST,
  input  wire logic [3:0]           ADDR,
  input  wire logic [7:0]           WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output var  logic [7:0]           RDATA,
  output var  logic                 DEV_CS_N,
  output var  logic                 DEV_WR_N,
  output var  logic                 DEV_RD_N,
  output var  logic                 DEV_PORT_SEL,
  input  wire ipc_pkg::ipc_byte_type DEV_D_IN,
  output var  ipc_pkg::ipc_byte_type DEV_D_OUT,
  output var  logic                 DEV_D_OE_N
);
  import ipc_pkg::*;

  // ============================================================
  // Software registers and device word builder
  ipc_state_type state_r;
  logic [3:0]    cnt_r;
  logic [2:0]    level_r;
  logic [7:0]    mask_r;
  logic [7:0]    word_r;
  logic          port_r;
  logic          is_read_r;
  logic [7:0]    read_val_r;
  logic          done_r;
  logic          busy;
  logic [7:0]    d_sync1_r;
  logic [7:0]    d_sync2_r;
  logic [7:0]    cmd_word;
  logic          cmd_port;
  logic          cmd_read;
  logic          cmd_valid;

  assign busy = (state_r != IPC_IDLE);

  // Device has no clock, so every command is one strobed bus cycle.
  function automatic logic [9:0] build_word(input logic [3:0] c,
                                            input logic [2:0] lvl,
                                            input logic [7:0] m);
    logic [9:0] w;
    w = {2'b00, 8'h00};
    case (c)
      `IPC_CMD_MASK:      w = {1'b1, `IPC_PORT_MASK, m};
      `IPC_CMD_NS_EOS:    w = {1'b1, `IPC_PORT_CMD, 8'h20};
      `IPC_CMD_SP_EOS:    w = {1'b1, `IPC_PORT_CMD, 5'h0c, lvl};
      `IPC_CMD_ROT_NS:    w = {1'b1, `IPC_PORT_CMD, 8'ha0};
      `IPC_CMD_ROT_SP:    w = {1'b1, `IPC_PORT_CMD, 5'h1c, lvl};
      `IPC_CMD_SET_PRIO:  w = {1'b1, `IPC_PORT_CMD, 5'h18, lvl};
      `IPC_CMD_ROT_AUTO:  w = {1'b1, `IPC_PORT_CMD, 8'h80};
      `IPC_CMD_ROT_OFF:   w = {1'b1, `IPC_PORT_CMD, 8'h00};
      `IPC_CMD_SMM_ON:    w = {1'b1, `IPC_PORT_CMD, 8'h68};
      `IPC_CMD_SMM_OFF:   w = {1'b1, `IPC_PORT_CMD, 8'h48};
      `IPC_CMD_READ_REQ:  w = {1'b1, `IPC_PORT_CMD, 8'h0a};
      `IPC_CMD_READ_ISV:  w = {1'b1, `IPC_PORT_CMD, 8'h0b};
      `IPC_CMD_READ_MASK: w = {1'b1, `IPC_PORT_MASK, 8'h00};
      default:            w = {2'b00, 8'h00};
    endcase
    return w;
  endfunction : build_word

  always_comb
  begin
    {cmd_valid, cmd_port, cmd_word} = build_word(WDATA[3:0], level_r, mask_r);
    cmd_read = (WDATA[3:0] == `IPC_CMD_READ_MASK);
  end

  // ============================================================
  // Level and mask shadow registers
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      level_r <= 3'h0;
      mask_r  <= 8'h00;
    end
    else if (WR && !busy)
    begin
      if (ADDR == `IPC_REG_LEVEL)
        level_r <= WDATA[2:0];
      if (ADDR == `IPC_REG_MASK)
        mask_r <= WDATA;
    end
  end

  // ============================================================
  // Device bus sequencer
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      state_r   <= IPC_IDLE;
      cnt_r     <= 4'h0;
      word_r    <= 8'h00;
      port_r    <= 1'b0;
      is_read_r <= 1'b0;
      done_r    <= 1'b0;
    end
    else
    begin
      case (state_r)
        IPC_IDLE:
        begin
          // Commands arriving while busy are dropped; software polls status.
          // Drives one chip; a cascade takes one controller each
          if (WR && ADDR == `IPC_REG_CMD && cmd_valid)
          begin
            word_r    <= cmd_word;
            port_r    <= cmd_port;
            is_read_r <= cmd_read;
            cnt_r     <= `IPC_SETUP_CYC;
            done_r    <= 1'b0;
            state_r   <= IPC_SETUP;
          end
        end
        IPC_SETUP:
        begin
          if (cnt_r == 4'h1)
          begin
            cnt_r   <= `IPC_STROBE_CYC;
            state_r <= IPC_STROBE;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        IPC_STROBE:
        begin
          if (cnt_r == 4'h1)
            state_r <= IPC_HOLD;
          else
            cnt_r <= cnt_r - 4'h1;
        end
        IPC_HOLD:
        begin
          done_r  <= 1'b1;
          state_r <= IPC_IDLE;
        end
        default:
          state_r <= IPC_IDLE;
      endcase
    end
  end

  // ============================================================
  // Pin drive, all from flops
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      DEV_CS_N     <= 1'b1;
      DEV_WR_N     <= 1'b1;
      DEV_RD_N     <= 1'b1;
      DEV_PORT_SEL <= 1'b0;
      DEV_D_OUT    <= 8'h00;
      DEV_D_OE_N   <= 1'b1;
    end
    else
    begin
      DEV_CS_N     <= !(state_r == IPC_SETUP || state_r == IPC_STROBE);
      DEV_WR_N     <= !(state_r == IPC_STROBE && !is_read_r);
      DEV_RD_N     <= !(state_r == IPC_STROBE && is_read_r);
      DEV_PORT_SEL <= port_r;
      DEV_D_OUT    <= word_r;
      DEV_D_OE_N   <= !(busy && !is_read_r);
    end
  end

  // ============================================================
  // Read capture: data pins are asynchronous, two stages first
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      d_sync1_r  <= 8'h00;
      d_sync2_r  <= 8'h00;
      read_val_r <= 8'h00;
    end
    else
    begin
      d_sync1_r <= DEV_D_IN;
      d_sync2_r <= d_sync1_r;
      if (state_r == IPC_HOLD && is_read_r)
        read_val_r <= d_sync2_r;
    end
  end

  // ============================================================
  // Software read port
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      RDATA <= 8'h00;
    else if (RD)
    begin
      case (ADDR)
        `IPC_REG_LEVEL:  RDATA <= {5'h00, level_r};
        `IPC_REG_MASK:   RDATA <= mask_r;
        `IPC_REG_STATUS: RDATA <= {6'h00, done_r, busy};
        `IPC_REG_RDATA:  RDATA <= read_val_r;
        default:         RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end

  // ============================================================
  // Checks
  sequence s_write_strobe;
    !DEV_CS_N && !DEV_WR_N [*3];
  endsequence

  AST_MASK_PORT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!DEV_WR_N && DEV_PORT_SEL) |-> (DEV_D_OUT == mask_r))
    else $error("mask write data differs from shadow");
  AST_CMD_FMT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!DEV_WR_N && !DEV_PORT_SEL) |->
      (DEV_D_OUT[4] == 1'b0) && (DEV_D_OUT[3] == 1'b0 || !DEV_D_OUT[7]))
    else $error("command word has illegal layout");
  AST_LVL_USE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!DEV_WR_N && !DEV_PORT_SEL && !DEV_D_OUT[3] && !DEV_D_OUT[6])
      |-> (DEV_D_OUT[2:0] == 3'h0))
    else $error("level bits set without select");
  AST_SMM_EN: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!DEV_WR_N && !DEV_PORT_SEL && DEV_D_OUT[3] && DEV_D_OUT[5])
      |-> DEV_D_OUT[6])
    else $error("mask mode bit without enable");
  AST_STROBE_LEN: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $fell(DEV_WR_N) |-> s_write_strobe ##1 DEV_WR_N)
    else $error("write strobe length wrong");
  AST_NOP: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!DEV_WR_N && !DEV_PORT_SEL && !DEV_D_OUT[3])
      |-> !(DEV_D_OUT[7:5] == 3'b010))
    else $error("no-op command code issued");
  AST_DONE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (WR && ADDR == `IPC_REG_CMD && !busy && cmd_valid) |-> ##6 done_r)
    else $error("command did not complete in time");
  AST_OE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !DEV_RD_N |-> DEV_D_OE_N)
    else $error("driving bus during read");
  AST_OE_WR: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !DEV_WR_N |-> !DEV_D_OE_N)
    else $error("write strobe without data drive");
endmodule : ipc_host
`default_nettype wire

// file: src/ipc_defs.svh
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH
// ============================================================
// Register map of the controller
`define IPC_REG_CMD       4'h0
`define IPC_REG_LEVEL     4'h1
`define IPC_REG_MASK      4'h2
`define IPC_REG_STATUS    4'h3
`define IPC_REG_RDATA     4'h4
// ============================================================
// Command codes written to the command register
`define IPC_CMD_MASK      4'h1
`define IPC_CMD_NS_EOS    4'h2
`define IPC_CMD_SP_EOS    4'h3
`define IPC_CMD_ROT_NS    4'h4
`define IPC_CMD_ROT_SP    4'h5
`define IPC_CMD_SET_PRIO  4'h6
`define IPC_CMD_ROT_AUTO  4'h7
`define IPC_CMD_ROT_OFF   4'h8
`define IPC_CMD_SMM_ON    4'h9
`define IPC_CMD_SMM_OFF   4'ha
`define IPC_CMD_READ_REQ  4'hb
`define IPC_CMD_READ_ISV  4'hc
`define IPC_CMD_READ_MASK 4'hd
// ============================================================
// Device word layout
`define IPC_PORT_CMD      1'b0
`define IPC_PORT_MASK     1'b1
`define IPC_CW2_ROT       7
`define IPC_CW2_SEL       6
`define IPC_CW2_EOS       5
`define IPC_CW3_BASE      8'h08
`define IPC_CW3_MASK_MODE_WRITE_ENABLE      6
`define IPC_CW3_SMM       5
`define IPC_CW3_RR        1
`define IPC_CW3_RIS       0
// ============================================================
// Bus timing in core cycles
`define IPC_STROBE_CYC    4'h3
`define IPC_SETUP_CYC     4'h1
`endif

// file: src/ipc_pkg.sv
package ipc_pkg;
  typedef enum {IPC_IDLE, IPC_SETUP, IPC_STROBE, IPC_HOLD} ipc_state_type;
  typedef logic [7:0] ipc_byte_type;
endpackage : ipc_pkg

// file: tb/ipc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Behavioural model of the controlled device
module ipc_dev_model
(
  input  wire logic       cs_n,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       port_sel,
  input  wire logic [7:0] d_wr,
  output var  logic [7:0] d_rd,
  input  wire logic [7:0] req,
  input  wire logic       ack,
  input  wire logic       auto_service_clear,
  output var  logic       int_out
);
  logic [7:0] mask_r = 8'h00, isr_r = 8'h00, irr_r = 8'h00;
  logic [2:0] bot_r = 3'h7;
  logic       smm_r = 1'b0, rota_r = 1'b0, armed = 1'b0;
  logic [7:0] wdat, elig, last_word;
  logic       wport_q = 1'b0;
  int         wcount = 0;
  function automatic logic [3:0] top_of(input logic [7:0] v);
    for (int i = 1; i <= 8; i++)
      if (v[3'(bot_r + i)]) return {1'b0, 3'(bot_r + i)};
    return 4'h8;
  endfunction : top_of
  function automatic void eos(input logic [7:0] v, input logic rot);
    logic [3:0] l;
    l = top_of(v);
    if (!l[3]) isr_r[l[2:0]] = 1'b0;
    if (!l[3] && rot) bot_r = l[2:0];
  endfunction : eos
  // Released bus shows the inverse, never a stale copy
  assign d_rd = (!cs_n && !rd_n && port_sel) ? mask_r : ~mask_r;
  always @(negedge wr_n)
    if (!cs_n) {armed, wport_q, wdat} = {1'b1, port_sel, d_wr};
  always @(posedge wr_n) if (armed)
  begin
    {armed, last_word} = {1'b0, wdat};
    wcount++;
    if (wdat[0] === 1'bx) ;
    else if (wport_q) mask_r = wdat;
    else if (wdat[4:3] == 2'b00)
      case (wdat[7:5])
        3'b001: eos(isr_r & (smm_r ? ~mask_r : 8'hff), 1'b0);
        3'b101: eos(isr_r, 1'b1);
        3'b011, 3'b111: {isr_r[wdat[2:0]], bot_r} = {1'b0, wdat[7] ? wdat[2:0] : bot_r};
        3'b110: bot_r = wdat[2:0];
        3'b100, 3'b000: rota_r = wdat[7];
        default: ;
      endcase
    else if (!wdat[7] && wdat[4:3] == 2'b01 && wdat[6]) smm_r = wdat[5];
  end
  always @*
  begin
    logic [3:0] t;
    t = top_of(isr_r);
    for (int l = 0; l < 8; l++)
      elig[l] = irr_r[l] & ~mask_r[l] & (smm_r | t[3] | (3'(l - bot_r - 1) < 3'(t[2:0] - bot_r - 1)));
    int_out = |elig;
  end
  always @(req) irr_r = irr_r | req;
  always @(posedge ack)
  begin
    logic [3:0] w;
    w = top_of(elig);
    if (!w[3]) {isr_r[w[2:0]], irr_r[w[2:0]]} = 2'b10;
  end
  always @(negedge ack) if (auto_service_clear) eos(isr_r, rota_r);
endmodule : ipc_dev_model
`default_nettype wire

// file: tb/tb_ipc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_ipc_host;
  import ipc_pkg::*;
  logic         clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, ack = 1'b0;
  logic         auto_service_clear = 1'b0;
  logic [3:0]   addr = 4'h0;
  logic [7:0]   wdata = 8'h00, rdata, req = 8'h00, s;
  logic         cs_n, wr_n, rd_n, psel, oe_n, int_out;
  ipc_byte_type d_in, d_out;
  int           error_cnt = 0, check_count = 0, cyc = 0, n;
  logic [7:0]   exp_w [2:12] = '{8'h20, 8'h63, 8'ha0, 8'he3, 8'hc3, 8'h80,
                                 8'h00, 8'h68, 8'h48, 8'h0a, 8'h0b};
  initial forever #12.5 clk = ~clk;
  ipc_host ipc_host_inst (.CORE_CLK(clk), .SRST(srst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DEV_CS_N(cs_n),
    .DEV_WR_N(wr_n), .DEV_RD_N(rd_n), .DEV_PORT_SEL(psel),
    .DEV_D_IN(d_in), .DEV_D_OUT(d_out), .DEV_D_OE_N(oe_n));
  ipc_dev_model ipc_dev_model_inst (.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .port_sel(psel), .d_wr(d_out), .d_rd(d_in), .req(req), .ack(ack),
    .auto_service_clear(auto_service_clear), .int_out(int_out));
  // ==========================================
  // Register access, ack pulse and finish tasks
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_done;
    for (int i = 0; i < 20; i++)
    begin
      rd_reg(`IPC_REG_STATUS, s);
      if (s[1] === 1'b1) break;
    end
    `CHK(s[1:0], 2'b10)
  endtask : wait_done
  task automatic cmd(input logic [3:0] c);
    wr_reg(`IPC_REG_CMD, {4'h0, c});
    wait_done();
  endtask : cmd
  task automatic pulse_ack;
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1;
  endtask : pulse_ack
  task automatic tally_and_finish;
    $display("Mismatches %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Hang guard, well above the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1 `CHK({cs_n, wr_n, rd_n, oe_n, rdata}, 12'hf00)
    wr_reg(`IPC_REG_MASK, 8'ha5);
    cmd(`IPC_CMD_MASK);
    `CHK(ipc_dev_model_inst.mask_r, 8'ha5)
    cmd(`IPC_CMD_READ_MASK);
    rd_reg(`IPC_REG_RDATA, s);
    `CHK(s, 8'ha5)
    wr_reg(`IPC_REG_MASK, 8'h00);
    cmd(`IPC_CMD_MASK);
    req <= 8'h14;
    pulse_ack();
    `CHK(ipc_dev_model_inst.isr_r, 8'h04)
    `CHK(int_out, 1'b0)
    cmd(`IPC_CMD_NS_EOS);
    `CHK({ipc_dev_model_inst.isr_r, int_out}, 9'h001)
    pulse_ack();
    wr_reg(`IPC_REG_LEVEL, 8'h04);
    cmd(`IPC_CMD_SP_EOS);
    `CHK(ipc_dev_model_inst.isr_r, 8'h00)
    wr_reg(`IPC_REG_LEVEL, 8'h03);
    for (int c = 2; c <= 12; c++)
    begin
      n = ipc_dev_model_inst.wcount;
      cmd(4'(c));
      `CHK({psel, ipc_dev_model_inst.last_word}, {1'b0, exp_w[c]})
      `CHK(ipc_dev_model_inst.wcount, n + 1)
    end
    `CHK(ipc_dev_model_inst.bot_r, 3'h3)
    n = ipc_dev_model_inst.wcount;
    wr_reg(`IPC_REG_CMD, 8'h0e);
    rd_reg(`IPC_REG_STATUS, s);
    `CHK(s[0], 1'b0)
    wr_reg(`IPC_REG_CMD, {4'h0, `IPC_CMD_NS_EOS});
    wr_reg(`IPC_REG_MASK, 8'hff);
    wr_reg(`IPC_REG_CMD, {4'h0, `IPC_CMD_ROT_OFF});
    wait_done();
    `CHK(ipc_dev_model_inst.last_word, 8'h20)
    `CHK(ipc_dev_model_inst.wcount, n + 1)
    cmd(`IPC_CMD_MASK);
    `CHK(ipc_dev_model_inst.mask_r, 8'h00)
    req <= 8'h20;
    pulse_ack();
    cmd(`IPC_CMD_ROT_NS);
    `CHK(ipc_dev_model_inst.isr_r, 8'h00)
    `CHK(ipc_dev_model_inst.bot_r, 3'h5)
    {auto_service_clear, req} <= {1'b1, 8'h41};
    pulse_ack();
    `CHK(ipc_dev_model_inst.isr_r, 8'h00)
    `CHK(ipc_dev_model_inst.irr_r, 8'h01)
    cmd(`IPC_CMD_ROT_AUTO);
    pulse_ack();
    `CHK(ipc_dev_model_inst.bot_r, 3'h0)
    `CHK(ipc_dev_model_inst.isr_r, 8'h00)
    auto_service_clear <= 1'b0;
    cmd(`IPC_CMD_ROT_OFF);
    req <= 8'h80;
    pulse_ack();
    wr_reg(`IPC_REG_MASK, 8'h80);
    cmd(`IPC_CMD_MASK);
    cmd(`IPC_CMD_SMM_ON);
    cmd(`IPC_CMD_NS_EOS);
    req <= 8'h01;
    #1 `CHK({ipc_dev_model_inst.isr_r, int_out}, 9'h101)
    cmd(`IPC_CMD_SMM_OFF);
    `CHK(int_out, 1'b0)
    wr_reg(`IPC_REG_LEVEL, 8'h07);
    cmd(`IPC_CMD_SP_EOS);
    `CHK({ipc_dev_model_inst.isr_r, int_out}, 9'h001)
    tally_and_finish();
  end
endmodule : tb_ipc_host
`default_nettype wire
